// ### logic/evt_ctrl.sv
// endianness selection and virtualization traps of a hart
`timescale 1ns/1ns

// How it works
// - instruction fetches are always little-endian
// - machine field picks machine data byte order
// - supervisor field zero without supervisor, else orders
// - user field zero without user, else orders
// - page-table accesses always follow supervisor field
// - supervisor/user fields may mirror other fields
// - single-endian devices hard-wire all fields
// - endianness reorders lanes, never moves bytes
// - fields accept any write, read legal
// - trap translation ops in supervisor when set
// - translation trap reads zero without supervisor
// - timed wait below machine traps after limit
// - wait trap reads zero without lower modes
// - user wait traps after limit with supervisor
// - trap supervisor return in supervisor when set
// - return trap reads zero without supervisor
// - modify-privilege uses previous mode for data
module evt_ctrl #(
	parameter bit HAS_S = 1'b1,
	parameter bit HAS_U = 1'b1,
	parameter logic [1:0] ENDIAN_MODE = evt_pkg::ENDIAN_BI,
	parameter logic [1:0] SBE_MIRROR = evt_pkg::MIRROR_NONE,
	parameter logic [1:0] UBE_MIRROR = evt_pkg::MIRROR_NONE,
	parameter bit WFI_TRAP_NOW = 1'b0,
	parameter int WFI_LIMIT = evt_pkg::WFI_LIMIT_CYC
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// register port
	input wire logic [evt_pkg::REG_ADDR_W-1:0] reg_addr_in,
	input wire logic [evt_pkg::REG_DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [evt_pkg::REG_DATA_W-1:0] reg_rdata_out,
	// hart state and instruction events
	input wire evt_pkg::evt_priv_t priv_in,
	input wire evt_pkg::evt_op_t op_in,
	input wire logic wfi_wake_in,
	output logic illegal_out,
	output logic wfi_done_out,
	// memory datapath
	input wire evt_pkg::evt_mem_req_t mem_req_in,
	output evt_pkg::evt_mem_out_t mem_out,
	input wire evt_pkg::evt_load_t load_in,
	output evt_pkg::evt_load_t load_out,
	// legal field view
	output evt_pkg::evt_ctrl_t ctrl_out
);
	import evt_pkg::*;

	typedef enum logic [1:0] {
		EVT_WFI_IDLE = 2'b00,
		EVT_WFI_WAIT = 2'b01
	} evt_wfi_state_t;

	evt_ctrl_t ctrl_reg;
	evt_ctrl_t eff;
	evt_wfi_state_t wfi_reg;
	logic wfi_timed_reg;
	logic [WFI_CNT_W-1:0] wfi_cnt_reg;
	logic [REG_DATA_W-1:0] reg_rdata_reg;
	logic illegal_reg;
	logic wfi_done_reg;
	evt_mem_out_t mem_reg;
	evt_load_t load_reg;
	evt_ctrl_t ctrl_view_reg;
	evt_priv_t data_priv;
	logic data_be;
	logic [DATA_W-1:0] st_swapped;
	logic [DATA_W-1:0] ld_swapped;
	logic op_is_vm;
	logic wfi_timed;
	logic [WFI_CNT_W-1:0] wfi_limit_m1;

	localparam bit HAS_LOWER = HAS_S | HAS_U;

	// a previous-privilege code is kept only if that mode exists
	function automatic logic priv_legal(input logic [1:0] p);
		return (p == EVT_PRIV_M) || (p == EVT_PRIV_S && HAS_S) || (p == EVT_PRIV_U && HAS_U);
	endfunction

	// legal read view of the stored fields, with hard-wiring and mirrors
	function automatic evt_ctrl_t legalize(input evt_ctrl_t c);
		evt_ctrl_t r;
		r = c;
		if (ENDIAN_MODE == ENDIAN_LE_ONLY) begin
			r.machine_big_endian = 1'b0;
			r.supervisor_big_endian = 1'b0;
			r.user_big_endian = 1'b0;
		end else if (ENDIAN_MODE == ENDIAN_BE_ONLY) begin
			r.machine_big_endian = 1'b1;
			r.supervisor_big_endian = 1'b1;
			r.user_big_endian = 1'b1;
		end
		if (SBE_MIRROR == MIRROR_MBE) begin
			r.supervisor_big_endian = r.machine_big_endian;
		end
		if (UBE_MIRROR == MIRROR_MBE) begin
			r.user_big_endian = r.machine_big_endian;
		end else if (UBE_MIRROR == MIRROR_SBE) begin
			r.user_big_endian = r.supervisor_big_endian;
		end
		if (!HAS_S) begin
			r.supervisor_big_endian = 1'b0;
			r.trap_vm_ops = 1'b0;
			r.trap_supervisor_return = 1'b0;
		end
		if (!HAS_U) begin
			r.user_big_endian = 1'b0;
			r.modify_privilege = 1'b0;
		end
		if (!HAS_LOWER) begin
			r.trap_wait_timeout = 1'b0;
		end
		if (!priv_legal(r.previous_machine_priv)) begin
			r.previous_machine_priv = EVT_PRIV_M;
		end
		return r;
	endfunction

	function automatic logic [REG_DATA_W-1:0] pack_ctrl(input evt_ctrl_t c);
		logic [REG_DATA_W-1:0] w;
		w = REG_ZERO;
		w[MBE_BIT] = c.machine_big_endian;
		w[SBE_BIT] = c.supervisor_big_endian;
		w[UBE_BIT] = c.user_big_endian;
		w[MODIFY_PRIVILEGE_BIT] = c.modify_privilege;
		w[MPP_LSB +: 2] = c.previous_machine_priv;
		w[TVM_BIT] = c.trap_vm_ops;
		w[TW_BIT] = c.trap_wait_timeout;
		w[TSR_BIT] = c.trap_supervisor_return;
		return w;
	endfunction

	function automatic evt_ctrl_t unpack_ctrl(input logic [REG_DATA_W-1:0] w,
		input evt_ctrl_t old);
		evt_ctrl_t c;
		c.machine_big_endian = w[MBE_BIT];
		c.supervisor_big_endian = w[SBE_BIT];
		c.user_big_endian = w[UBE_BIT];
		c.modify_privilege = w[MODIFY_PRIVILEGE_BIT];
		// an unsupported mode code leaves the previous one in place
		c.previous_machine_priv = priv_legal(w[MPP_LSB +: 2]) ? w[MPP_LSB +: 2] :
			old.previous_machine_priv;
		c.trap_vm_ops = w[TVM_BIT];
		c.trap_wait_timeout = w[TW_BIT];
		c.trap_supervisor_return = w[TSR_BIT];
		return c;
	endfunction

	function automatic logic order_of(input evt_ctrl_t c, input logic [1:0] p);
		logic r;
		unique case (p)
			EVT_PRIV_M: r = c.machine_big_endian;
			EVT_PRIV_S: r = c.supervisor_big_endian;
			EVT_PRIV_U: r = c.user_big_endian;
			default: r = c.machine_big_endian;
		endcase
		return r;
	endfunction

	assign eff = legalize(ctrl_reg);

	// control field storage
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			ctrl_reg <= CTRL_RESET;
		end else if (reg_wr_in && reg_addr_in == CTRL_OFFS) begin
			ctrl_reg <= legalize(unpack_ctrl(reg_wdata_in, eff));
		end
	end

	// read data, one cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			reg_rdata_reg <= REG_ZERO;
		end else if (reg_rd_in) begin
			if (reg_addr_in == CTRL_OFFS) begin
				reg_rdata_reg <= pack_ctrl(eff);
			end else if (reg_addr_in == STAT_OFFS) begin
				reg_rdata_reg <= REG_ZERO |
					(REG_DATA_W'(priv_in) << STAT_PRIV_LSB) |
					(REG_DATA_W'(data_priv) << STAT_EFF_LSB) |
					(REG_DATA_W'(wfi_reg == EVT_WFI_WAIT) << STAT_WAIT_BIT) |
					(REG_DATA_W'(wfi_timed_reg) << STAT_TIMED_BIT);
			end else begin
				reg_rdata_reg <= REG_ZERO;
			end
		end else begin
			reg_rdata_reg <= REG_ZERO;
		end
	end

	// data byte order: previous mode under modify-privilege
	always_comb begin
		data_priv = eff.modify_privilege ? evt_priv_t'(eff.previous_machine_priv) :
			priv_in;
		if (mem_req_in.fetch) begin
			data_be = 1'b0;
		end else if (mem_req_in.implicit_acc) begin
			data_be = eff.supervisor_big_endian;
		end else begin
			data_be = order_of(eff, data_priv);
		end
	end

	evt_lane_swap #(.BYTES(DATA_BYTES)) u_store_swap (
		.data_in(mem_req_in.wdata),
		.size_in(mem_req_in.size),
		.swap_in(data_be),
		.data_out(st_swapped)
	);

	evt_lane_swap #(.BYTES(DATA_BYTES)) u_load_swap (
		.data_in(load_in.rdata),
		.size_in(load_in.size),
		.swap_in(load_in.big_endian),
		.data_out(ld_swapped)
	);

	// address passes unchanged; only the lanes of the quantity move
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			mem_reg <= '0;
		end else begin
			mem_reg.valid <= mem_req_in.valid;
			mem_reg.big_endian <= data_be;
			mem_reg.size <= mem_req_in.size;
			mem_reg.addr <= mem_req_in.addr;
			mem_reg.wdata <= st_swapped;
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			load_reg <= '0;
		end else begin
			load_reg.valid <= load_in.valid;
			load_reg.big_endian <= load_in.big_endian;
			load_reg.size <= load_in.size;
			load_reg.rdata <= ld_swapped;
		end
	end

	// instruction checks
	always_comb begin
		op_is_vm = (op_in == EVT_OP_XLAT_RD) || (op_in == EVT_OP_XLAT_WR) ||
			(op_in == EVT_OP_FENCE) || (op_in == EVT_OP_INVAL);
		// user-mode wait is timed on any hart with supervisor mode
		wfi_timed = (priv_in != EVT_PRIV_M) && (eff.trap_wait_timeout ||
			(HAS_S && priv_in == EVT_PRIV_U));
		wfi_limit_m1 = WFI_CNT_W'(WFI_LIMIT - 1);
	end

	// wait-for-interrupt tracking and illegal-instruction pulses
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			wfi_reg <= EVT_WFI_IDLE;
			wfi_timed_reg <= 1'b0;
			wfi_cnt_reg <= '0;
			illegal_reg <= 1'b0;
			wfi_done_reg <= 1'b0;
		end else begin
			illegal_reg <= 1'b0;
			wfi_done_reg <= 1'b0;
			unique case (wfi_reg)
				EVT_WFI_IDLE: begin
					if (op_is_vm && priv_in == EVT_PRIV_S && eff.trap_vm_ops) begin
						illegal_reg <= 1'b1;
					end else if (op_in == EVT_OP_SRET && priv_in == EVT_PRIV_S &&
						eff.trap_supervisor_return) begin
						illegal_reg <= 1'b1;
					end else if (op_in == EVT_OP_WFI) begin
						if (wfi_timed && WFI_TRAP_NOW) begin
							illegal_reg <= 1'b1;
						end else begin
							wfi_reg <= EVT_WFI_WAIT;
							wfi_timed_reg <= wfi_timed;
							wfi_cnt_reg <= '0;
						end
					end
				end
				EVT_WFI_WAIT: begin
					// a wake in the last counted cycle still completes the wait
					if (wfi_wake_in) begin
						wfi_done_reg <= 1'b1;
						wfi_reg <= EVT_WFI_IDLE;
						wfi_timed_reg <= 1'b0;
					end else if (wfi_timed_reg && wfi_cnt_reg == wfi_limit_m1) begin
						illegal_reg <= 1'b1;
						wfi_reg <= EVT_WFI_IDLE;
						wfi_timed_reg <= 1'b0;
					end else if (wfi_timed_reg) begin
						wfi_cnt_reg <= wfi_cnt_reg + WFI_CNT_W'(1);
					end
				end
				default: begin
					wfi_reg <= EVT_WFI_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			ctrl_view_reg <= CTRL_RESET;
		end else begin
			ctrl_view_reg <= eff;
		end
	end

	assign reg_rdata_out = reg_rdata_reg;
	assign illegal_out = illegal_reg;
	assign wfi_done_out = wfi_done_reg;
	assign mem_out = mem_reg;
	assign load_out = load_reg;
	assign ctrl_out = ctrl_view_reg;

endmodule

// ### logic/evt_lane_swap.sv
// byte-lane reversal of a multibyte quantity
`timescale 1ns/1ns
module evt_lane_swap #(
	parameter int BYTES = 8
) (
	// quantity in
	input wire logic [BYTES*8-1:0] data_in,
	input wire logic [1:0] size_in,
	input wire logic swap_in,
	// quantity out
	output logic [BYTES*8-1:0] data_out
);
	import evt_pkg::*;

	// only the low 2^size bytes are reordered; the address map is untouched
	function automatic logic [BYTES*8-1:0] reverse(input logic [BYTES*8-1:0] d,
		input logic [1:0] sz);
		logic [BYTES*8-1:0] r;
		int n;
		r = d;
		n = 1 << sz;
		for (int i = 0; i < BYTES; i++) begin
			if (i < n) begin
				r[i*8 +: 8] = d[(n-1-i)*8 +: 8];
			end
		end
		return r;
	endfunction

	always_comb begin
		data_out = swap_in ? reverse(data_in, size_in) : data_in;
	end

endmodule

// ### logic/evt_pkg.sv
// shared constants and types for the endian and virtualization trap control
package evt_pkg;

	localparam int DATA_BYTES = 8;
	localparam int DATA_W = DATA_BYTES * 8;
	localparam int ADDR_W = 64;
	localparam int REG_ADDR_W = 8;
	localparam int REG_DATA_W = 32;

	// register offsets
	localparam logic [REG_ADDR_W-1:0] CTRL_OFFS = 8'h00;
	localparam logic [REG_ADDR_W-1:0] STAT_OFFS = 8'h04;

	// control register field positions
	localparam int MBE_BIT = 0;
	localparam int SBE_BIT = 1;
	localparam int UBE_BIT = 2;
	localparam int MODIFY_PRIVILEGE_BIT = 3;
	localparam int MPP_LSB = 4;
	localparam int TVM_BIT = 6;
	localparam int TW_BIT = 7;
	localparam int TSR_BIT = 8;

	// status register field positions
	localparam int STAT_PRIV_LSB = 0;
	localparam int STAT_EFF_LSB = 2;
	localparam int STAT_WAIT_BIT = 4;
	localparam int STAT_TIMED_BIT = 5;

	localparam logic [REG_DATA_W-1:0] REG_ZERO = 32'h0000_0000;

	// wait-for-interrupt time limit
	localparam int CLK_PERIOD_NS = 100;
	localparam int WFI_LIMIT_NS = 10000;
	localparam int WFI_LIMIT_CYC = (WFI_LIMIT_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(WFI_LIMIT_NS / CLK_PERIOD_NS);
	localparam int WFI_CNT_W = 16;

	// endian capability of the implementation
	localparam logic [1:0] ENDIAN_BI = 2'h0;
	localparam logic [1:0] ENDIAN_LE_ONLY = 2'h1;
	localparam logic [1:0] ENDIAN_BE_ONLY = 2'h2;

	// read-only mirroring choices
	localparam logic [1:0] MIRROR_NONE = 2'h0;
	localparam logic [1:0] MIRROR_MBE = 2'h1;
	localparam logic [1:0] MIRROR_SBE = 2'h2;

	typedef enum logic [1:0] {
		EVT_PRIV_U = 2'b00,
		EVT_PRIV_S = 2'b01,
		EVT_PRIV_M = 2'b11
	} evt_priv_t;

	typedef enum logic [2:0] {
		EVT_OP_NONE = 3'b000,
		EVT_OP_XLAT_RD = 3'b001,
		EVT_OP_XLAT_WR = 3'b010,
		EVT_OP_FENCE = 3'b011,
		EVT_OP_INVAL = 3'b100,
		EVT_OP_SRET = 3'b101,
		EVT_OP_WFI = 3'b110
	} evt_op_t;

	// access sizes: 1, 2, 4, 8 bytes
	localparam logic [1:0] SIZE_B = 2'h0;
	localparam logic [1:0] SIZE_H = 2'h1;
	localparam logic [1:0] SIZE_W = 2'h2;
	localparam logic [1:0] SIZE_D = 2'h3;

	typedef struct packed {
		logic valid;
		logic fetch;
		logic implicit_acc;
		logic [1:0] size;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} evt_mem_req_t;

	typedef struct packed {
		logic valid;
		logic big_endian;
		logic [1:0] size;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} evt_mem_out_t;

	typedef struct packed {
		logic valid;
		logic big_endian;
		logic [1:0] size;
		logic [DATA_W-1:0] rdata;
	} evt_load_t;

	typedef struct packed {
		logic machine_big_endian;
		logic supervisor_big_endian;
		logic user_big_endian;
		logic modify_privilege;
		logic [1:0] previous_machine_priv;
		logic trap_vm_ops;
		logic trap_wait_timeout;
		logic trap_supervisor_return;
	} evt_ctrl_t;

	localparam evt_ctrl_t CTRL_RESET = '{default: 1'b0};

endpackage

// ### tb/evt_ctrl_checker.sv
// port-level assertions for the endian and trap control block
`timescale 1ns/1ns
module evt_ctrl_checker
	import evt_pkg::*;
#(
	parameter int WFI_LIMIT = 100
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// watched ports
	input wire evt_pkg::evt_priv_t priv_in,
	input wire evt_pkg::evt_op_t op_in,
	input wire logic wfi_wake_in,
	input wire logic illegal_out,
	input wire logic wfi_done_out,
	input wire evt_pkg::evt_mem_req_t mem_req_in,
	input wire evt_pkg::evt_mem_out_t mem_out,
	input wire evt_pkg::evt_load_t load_in,
	input wire evt_pkg::evt_load_t load_out,
	input wire evt_pkg::evt_ctrl_t ctrl_out
);
	localparam int LIM_HI = WFI_LIMIT + 2;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	logic ex;
	// stable field view skips requests sampled just after ctrl_out changes, not one sampled while ctrl_out still lags a write
	assign ex = mem_req_in.valid && !mem_req_in.fetch && !mem_req_in.implicit_acc;
	AST_FETCH_LE: assert property (mem_req_in.valid && mem_req_in.fetch
		|=> mem_out.valid && !mem_out.big_endian) else $error("fetch not little-endian");
	AST_M_ORDER: assert property (ex && priv_in == EVT_PRIV_M && $stable(ctrl_out)
		&& !ctrl_out.modify_privilege |=> mem_out.big_endian == $past(ctrl_out.machine_big_endian))
		else $error("machine data order wrong");
	AST_PT_ORDER: assert property (mem_req_in.valid && mem_req_in.implicit_acc
		&& !mem_req_in.fetch && $stable(ctrl_out)
		|=> mem_out.big_endian == $past(ctrl_out.supervisor_big_endian))
		else $error("page-table order wrong");
	AST_MODIFY_PRIVILEGE: assert property (ex && priv_in == EVT_PRIV_M && ctrl_out.modify_privilege
		&& ctrl_out.previous_machine_priv == 2'h0 && $stable(ctrl_out)
		|=> mem_out.big_endian == $past(ctrl_out.user_big_endian)) else $error("modify_privilege order wrong");
	AST_ADDR_KEEP: assert property (mem_req_in.valid |=> mem_out.addr == $past(mem_req_in.addr)
		&& mem_out.size == $past(mem_req_in.size)) else $error("address or size altered");
	AST_LOAD_SWAP: assert property (load_in.valid && load_in.big_endian && load_in.size == SIZE_D
		|=> load_out.rdata[7:0] == $past(load_in.rdata[63:56])
		&& load_out.rdata[63:56] == $past(load_in.rdata[7:0])) else $error("load lanes wrong");
	AST_TVM: assert property (op_in inside {EVT_OP_XLAT_RD, EVT_OP_XLAT_WR, EVT_OP_FENCE,
		EVT_OP_INVAL} && priv_in == EVT_PRIV_S && $stable(ctrl_out)
		|=> illegal_out == $past(ctrl_out.trap_vm_ops)) else $error("translation trap wrong");
	AST_TSR: assert property (op_in == EVT_OP_SRET && priv_in == EVT_PRIV_S && $stable(ctrl_out)
		|=> illegal_out == $past(ctrl_out.trap_supervisor_return)) else $error("return trap wrong");
	AST_TW: assert property (op_in == EVT_OP_WFI && priv_in == EVT_PRIV_S
		&& ctrl_out.trap_wait_timeout |-> ##[1:LIM_HI] (illegal_out || wfi_done_out))
		else $error("timed wait not bounded");
	AST_UWFI: assert property (op_in == EVT_OP_WFI && priv_in == EVT_PRIV_U
		|-> ##[1:LIM_HI] (illegal_out || wfi_done_out)) else $error("user wait not bounded");
	COV_ILL: cover property (illegal_out);
	COV_DONE: cover property (wfi_done_out);
	COV_BE: cover property (mem_out.valid && mem_out.big_endian);
endmodule

bind evt_ctrl evt_ctrl_checker #(.WFI_LIMIT(WFI_LIMIT)) u_chk (.ref_clk_in, .reset_in,
	.priv_in, .op_in, .wfi_wake_in, .illegal_out, .wfi_done_out, .mem_req_in, .mem_out,
	.load_in, .load_out, .ctrl_out);

// ### tb/tb_evt_ctrl.sv
// self-checking bench for the endian and trap control block
`timescale 1ns/1ns
module tb_evt_ctrl;
	import evt_pkg::*;
	localparam int LIM = 4;
	logic ref_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [31:0] reg_rdata_out;
	evt_priv_t priv_in = EVT_PRIV_M;
	evt_op_t op_in = EVT_OP_NONE;
	logic wfi_wake_in = 1'b0;
	logic illegal_out;
	logic wfi_done_out;
	evt_mem_req_t mem_req_in = '0;
	evt_mem_out_t mem_out;
	evt_load_t load_in = '0;
	evt_load_t load_out;
	evt_ctrl_t ctrl_out;
	int err_total = 0;
	int n_checks = 0;
	logic [31:0] d;

	evt_ctrl #(.WFI_LIMIT(LIM)) uut (.ref_clk_in, .reset_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out, .priv_in, .op_in, .wfi_wake_in, .illegal_out,
		.wfi_done_out, .mem_req_in, .mem_out, .load_in, .load_out, .ctrl_out);

	always #50 ref_clk_in = ~ref_clk_in;

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
		// settle time so the field copy is steady before traffic
		repeat (2) @(posedge ref_clk_in);
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		@(negedge ref_clk_in);
		d = reg_rdata_out;
	endtask

	task automatic mem(input evt_priv_t p, input logic f, input logic im, input logic [1:0] sz,
		input logic [63:0] wd, input logic be, input logic [63:0] ewd);
		@(posedge ref_clk_in);
		priv_in <= p;
		mem_req_in <= '{1'b1, f, im, sz, 64'h1000, wd};
		@(posedge ref_clk_in);
		mem_req_in.valid <= 1'b0;
		@(negedge ref_clk_in);
		chk(mem_out.big_endian, be);
		chk(mem_out.wdata, ewd);
		chk(mem_out.addr, 64'h1000);
	endtask

	task automatic op(input evt_priv_t p, input evt_op_t o, input logic e);
		@(posedge ref_clk_in);
		priv_in <= p;
		op_in <= o;
		@(posedge ref_clk_in);
		op_in <= EVT_OP_NONE;
		@(negedge ref_clk_in);
		chk(illegal_out, e);
	endtask

	task automatic wfi(input evt_priv_t p, input int wk, input logic ei);
		op(p, EVT_OP_WFI, 1'b0);
		for (int i = 0; i < LIM + 8; i++) begin
			@(posedge ref_clk_in);
			if (i == wk) wfi_wake_in <= 1'b1;
			@(negedge ref_clk_in);
			if (illegal_out === 1'b1 || wfi_done_out === 1'b1) break;
		end
		chk(illegal_out, ei);
		chk(wfi_done_out, !ei);
		@(posedge ref_clk_in);
		wfi_wake_in <= 1'b0;
	endtask

	task automatic t_regs;
		wr(CTRL_OFFS, 32'hFFFF_FFFF);
		rd(CTRL_OFFS);
		chk(d, 32'h1FF);
		rd(8'h0C);
		chk(d, 32'h0);
		wr(CTRL_OFFS, 32'h0);
		rd(CTRL_OFFS);
		chk(d, 32'h0);
		// machine mode, no modify-privilege: current and data mode both read 11
		rd(STAT_OFFS);
		chk(d, 32'hF);
	endtask

	task automatic t_endian;
		wr(CTRL_OFFS, 32'h5);
		mem(EVT_PRIV_M, 0, 0, SIZE_W, 64'hCAFE0000_11223344, 1, 64'hCAFE0000_44332211);
		mem(EVT_PRIV_S, 0, 0, SIZE_W, 64'h11223344, 0, 64'h11223344);
		mem(EVT_PRIV_U, 0, 0, SIZE_H, 64'hAABB, 1, 64'hBBAA);
		mem(EVT_PRIV_M, 1, 0, SIZE_W, 64'h11223344, 0, 64'h11223344);
		mem(EVT_PRIV_U, 0, 1, SIZE_H, 64'hAABB, 0, 64'hAABB);
		wr(CTRL_OFFS, 32'h2);
		mem(EVT_PRIV_M, 0, 1, SIZE_H, 64'hAABB, 1, 64'hBBAA);
		mem(EVT_PRIV_M, 0, 0, SIZE_H, 64'hAABB, 0, 64'hAABB);
		wr(CTRL_OFFS, 32'hC);
		mem(EVT_PRIV_M, 0, 0, SIZE_D, 64'h0102030405060708, 1, 64'h0807060504030201);
		@(posedge ref_clk_in);
		load_in <= '{1'b1, 1'b1, SIZE_D, 64'h0102030405060708};
		@(posedge ref_clk_in);
		load_in.big_endian <= 1'b0;
		@(negedge ref_clk_in);
		chk(load_out.rdata, 64'h0807060504030201);
		@(posedge ref_clk_in);
		load_in.valid <= 1'b0;
		@(negedge ref_clk_in);
		chk(load_out.rdata, 64'h0102030405060708);
	endtask

	task automatic t_traps;
		wr(CTRL_OFFS, 32'h140);
		for (int i = 1; i < 6; i++) op(EVT_PRIV_S, evt_op_t'(i), 1'b1);
		op(EVT_PRIV_M, EVT_OP_SRET, 1'b0);
		wr(CTRL_OFFS, 32'h0);
		for (int i = 1; i < 6; i++) op(EVT_PRIV_S, evt_op_t'(i), 1'b0);
	endtask

	task automatic t_wfi;
		wr(CTRL_OFFS, 32'h80);
		wfi(EVT_PRIV_S, 99, 1'b1);
		wfi(EVT_PRIV_S, 1, 1'b0);
		wfi(EVT_PRIV_M, 6, 1'b0);
		wr(CTRL_OFFS, 32'h0);
		wfi(EVT_PRIV_U, 99, 1'b1);
		wfi(EVT_PRIV_S, 6, 1'b0);
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		t_regs;
		t_endian;
		t_traps;
		t_wfi;
		test_done;
	end

	initial begin
		repeat (3000) @(posedge ref_clk_in);
		err_total++;
		test_done;
	end
endmodule
